// >>> hdl/smc_pkg.sv
// constants for the supply monitor control block
package smc_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'hDF;
    localparam logic [7:0] CTRL_RESET = 8'hDE;
    localparam int BIT_DIG_OK = 7;
    localparam int BIT_ANA_OK = 6;
    localparam int BIT_FLAG = 5;
    localparam int BIT_DTRIP_HI = 4;
    localparam int BIT_DTRIP_LO = 3;
    localparam int BIT_ATRIP_HI = 2;
    localparam int BIT_ATRIP_LO = 1;
    localparam int BIT_ENABLE = 0;
    // trip level codes: 4.63 V, 3.08 V, 2.93 V, 2.63 V
    localparam logic [1:0] TRIP_4V63 = 2'h0;
    localparam logic [1:0] TRIP_3V08 = 2'h1;
    localparam logic [1:0] TRIP_2V93 = 2'h2;
    localparam logic [1:0] TRIP_2V63 = 2'h3;
    localparam int CLK_HZ = 40000000;
    localparam int HOLD_MS = 250;
    localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
    // glitch filter length in cycles
    localparam int GLITCH_CYCLES = 8;
endpackage : smc_pkg

// >>> hdl/smc_top.sv
// supply monitor control register, glitch filter and low-supply flag
//
// Contract
// (RULE_01) monitor runs only while enable bit set
// (RULE_02) digital trip level from two-bit field
// (RULE_03) analog trip level, same two-bit coding
// (RULE_04) bit 7 shows digital rail comparator
// (RULE_05) bit 6 shows analog rail comparator
// (RULE_06) bit 5 flag sets on any low rail
// (RULE_07) flag clears after 250 ms rails good
// (RULE_08) software clear ignored while rail low
// (RULE_09) interrupt passed only when enable set
// (RULE_10) comparator glitches are filtered out
// (RULE_11) rail drop restarts the hold count
// (RULE_12) hold interval counted on reference clock
`timescale 1ns/1ps
module smc_top #(
    parameter int HOLD_COUNT = smc_pkg::HOLD_CYCLES
) (
    input wire logic sys_clk, // core clock, 40 MHz
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] sfr_addr, // special register address
    input wire logic sfr_wr, // write strobe
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_rd, // read strobe
    output logic [7:0] sfr_rdata_ff, // read data, registered, zero when not reading
    input wire logic dig_cmp_raw, // digital comparator pin
    input wire logic ana_cmp_raw, // analog comparator pin
    input wire logic secondary_interrupt_enable, // core irq enable
    output logic monitor_enable_ff, // comparator enable out
    output logic [1:0] digital_trip_ff, // digital trip code out
    output logic [1:0] analog_trip_ff, // analog trip code out
    output logic low_supply_irq_ff // interrupt to core
);
    logic [2:0] dig_sync_ff;
    logic [2:0] ana_sync_ff;
    logic digital_rail_ok_ff;
    logic analog_rail_ok_ff;
    logic [3:0] glitch_cnt_ff;
    logic low_supply_flag_ff;
    logic [31:0] hold_cnt_ff;
    logic [31:0] nxt_hold_cnt;
    logic [3:0] nxt_glitch_cnt;
    logic nxt_flag;
    logic nxt_irq;
    logic [7:0] nxt_rdata;

    wire ctrl_hit = sfr_addr == smc_pkg::CTRL_ADDR;
    wire ctrl_wr = sfr_wr && ctrl_hit;
    wire dig_stable = dig_sync_ff[1] == dig_sync_ff[2];
    wire ana_stable = ana_sync_ff[1] == ana_sync_ff[2];
    // a differing raw state must persist to count as a change
    wire filt_diff = (dig_sync_ff[2] != digital_rail_ok_ff) ||
                     (ana_sync_ff[2] != analog_rail_ok_ff);
    wire filt_take = filt_diff && dig_stable && ana_stable &&
                     glitch_cnt_ff == 4'(smc_pkg::GLITCH_CYCLES - 1);
    wire rail_low = monitor_enable_ff &&
                    !(digital_rail_ok_ff && analog_rail_ok_ff);
    wire hold_done = hold_cnt_ff == 32'(HOLD_COUNT - 1);
    wire sw_flag_wr = ctrl_wr;
    wire sw_flag_val = sfr_wdata[smc_pkg::BIT_FLAG];
    wire [7:0] ctrl_view = {digital_rail_ok_ff, analog_rail_ok_ff,
                            low_supply_flag_ff, digital_trip_ff,
                            analog_trip_ff, monitor_enable_ff};

    // glitch filter counter, reset whenever inputs disagree
    assign nxt_glitch_cnt = (!filt_diff || !dig_stable || // RULE_10
                             !ana_stable || filt_take) ? 4'h0 :
                            glitch_cnt_ff + 4'h1;

    // hold counter only runs while flag pending and no rail is low with the monitor enabled
    assign nxt_hold_cnt = (rail_low || !low_supply_flag_ff ||
                           hold_done) ? 32'h0 : // RULE_07 RULE_11
                          hold_cnt_ff + 32'h1; // RULE_12

    // set has priority; software clear blocked while a rail is low
    assign nxt_flag = rail_low ? 1'b1 : // RULE_06 RULE_08
                      (low_supply_flag_ff && hold_done) ? 1'b0 : // RULE_07
                      sw_flag_wr ? sw_flag_val : low_supply_flag_ff;

    assign nxt_irq = nxt_flag && secondary_interrupt_enable; // RULE_09
    assign nxt_rdata = (sfr_rd && ctrl_hit) ? ctrl_view : 8'h00;

    // three-stage synchronisers for the digital and analog comparator outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dig_sync_ff <= 3'h7;
            ana_sync_ff <= 3'h7;
        end
        else
        begin
            dig_sync_ff <= {dig_sync_ff[1:0], dig_cmp_raw};
            ana_sync_ff <= {ana_sync_ff[1:0], ana_cmp_raw};
        end
    end

    // filtered comparator state, read back in bits 7 and 6
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            digital_rail_ok_ff <= smc_pkg::CTRL_RESET[smc_pkg::BIT_DIG_OK];
            analog_rail_ok_ff <= smc_pkg::CTRL_RESET[smc_pkg::BIT_ANA_OK];
            glitch_cnt_ff <= 4'h0;
        end
        else
        begin
            glitch_cnt_ff <= nxt_glitch_cnt;
            if (filt_take)
            begin
                digital_rail_ok_ff <= dig_sync_ff[2]; // RULE_04
                analog_rail_ok_ff <= ana_sync_ff[2]; // RULE_05
            end
        end
    end

    // control fields written by software
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            monitor_enable_ff <= smc_pkg::CTRL_RESET[smc_pkg::BIT_ENABLE];
            digital_trip_ff <= smc_pkg::CTRL_RESET[4:3];
            analog_trip_ff <= smc_pkg::CTRL_RESET[2:1];
        end
        else if (ctrl_wr)
        begin
            monitor_enable_ff <= sfr_wdata[smc_pkg::BIT_ENABLE]; // RULE_01
            digital_trip_ff <= sfr_wdata[4:3]; // RULE_02
            analog_trip_ff <= sfr_wdata[2:1]; // RULE_03
        end
    end

    // flag, hold counter, interrupt and read data
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_supply_flag_ff <= smc_pkg::CTRL_RESET[smc_pkg::BIT_FLAG];
            hold_cnt_ff <= 32'h0;
            low_supply_irq_ff <= 1'b0;
            sfr_rdata_ff <= 8'h00;
        end
        else
        begin
            low_supply_flag_ff <= nxt_flag;
            hold_cnt_ff <= nxt_hold_cnt;
            low_supply_irq_ff <= nxt_irq;
            sfr_rdata_ff <= nxt_rdata;
        end
    end

    sequence s_rail_low;
        rail_low;
    endsequence

    sequence s_flag_up;
        ##1 low_supply_flag_ff;
    endsequence

    property p_flag_sets;
        @(posedge sys_clk) disable iff (!rstn)
        s_rail_low |-> s_flag_up;
    endproperty
    a_flag_sets: assert property (p_flag_sets) // RULE_06
        else $error("flag not set on low rail");

    property p_no_clear_low;
        @(posedge sys_clk) disable iff (!rstn)
        (rail_low && ctrl_wr && !sw_flag_val) |=> low_supply_flag_ff;
    endproperty
    a_no_clear_low: assert property (p_no_clear_low) // RULE_08
        else $error("flag cleared while rail low");

    property p_auto_clear;
        @(posedge sys_clk) disable iff (!rstn)
        (low_supply_flag_ff && hold_done && !rail_low) |=>
            !low_supply_flag_ff || $past(ctrl_wr);
    endproperty
    a_auto_clear: assert property (p_auto_clear) // RULE_07
        else $error("flag not cleared at hold expiry");

    property p_restart;
        @(posedge sys_clk) disable iff (!rstn)
        rail_low |=> hold_cnt_ff == 32'h0;
    endproperty
    a_restart: assert property (p_restart) // RULE_11
        else $error("hold count not restarted");

    property p_irq_gate;
        @(posedge sys_clk) disable iff (!rstn)
        low_supply_irq_ff |-> $past(secondary_interrupt_enable) &&
            low_supply_flag_ff;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RULE_09
        else $error("interrupt without enable");

    property p_glitch;
        @(posedge sys_clk) disable iff (!rstn)
        $changed(digital_rail_ok_ff) |->
            $past(dig_sync_ff[2]) == digital_rail_ok_ff;
    endproperty
    a_glitch: assert property (p_glitch) // RULE_10
        else $error("filtered state not from synchroniser");

    property p_disabled_quiet;
        @(posedge sys_clk) disable iff (!rstn)
        (!monitor_enable_ff && !low_supply_flag_ff && !ctrl_wr) |=>
            !low_supply_flag_ff;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // RULE_01
        else $error("monitor active while disabled");

    property p_read_view;
        @(posedge sys_clk) disable iff (!rstn)
        (sfr_rd && ctrl_hit) |=> sfr_rdata_ff[7:6] ==
            $past({digital_rail_ok_ff, analog_rail_ok_ff});
    endproperty
    a_read_view: assert property (p_read_view) // RULE_04 RULE_05
        else $error("comparator bits read wrong");

    property p_trip_write;
        @(posedge sys_clk) disable iff (!rstn)
        ctrl_wr |=> digital_trip_ff == $past(sfr_wdata[4:3]) &&
            analog_trip_ff == $past(sfr_wdata[2:1]);
    endproperty
    a_trip_write: assert property (p_trip_write) // RULE_02 RULE_03
        else $error("trip code not stored");

    property p_hold_bound;
        @(posedge sys_clk) disable iff (!rstn)
        hold_cnt_ff < 32'(HOLD_COUNT);
    endproperty
    a_hold_bound: assert property (p_hold_bound) // RULE_12
        else $error("hold count past terminal");
endmodule : smc_top

// >>> dv/smc_core_model.sv
// core side model: samples the monitor interrupt line
`timescale 1ns/1ps
module smc_core_model (
    input wire logic sys_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic irq, // level interrupt from the monitor
    output logic [7:0] irq_cnt_ff // requests seen
);
    logic irq_d_ff;
    // level request, counted once per assertion so a stuck line shows
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_d_ff <= 1'b0;
            irq_cnt_ff <= 8'h00;
        end
        else
        begin
            irq_d_ff <= irq;
            if (irq && !irq_d_ff)
                irq_cnt_ff <= irq_cnt_ff + 8'h01;
        end
    end
endmodule : smc_core_model

// >>> dv/smc_top_tb_top.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/1ps
module smc_top_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd_en = 1'b0;
    logic dig = 1'b1;
    logic ana = 1'b1;
    logic sie = 1'b1;
    logic [7:0] rdata;
    logic men;
    logic [1:0] dtrip;
    logic [1:0] atrip;
    logic irq;
    logic [7:0] irq_cnt;
    logic [7:0] d;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    always #12.5 sys_clk = ~sys_clk;
    // short hold count keeps the run brief
    smc_top #(.HOLD_COUNT(20)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .sfr_addr(addr), .sfr_wr(wr_en), .sfr_wdata(wdata),
        .sfr_rd(rd_en), .sfr_rdata_ff(rdata), .dig_cmp_raw(dig),
        .ana_cmp_raw(ana), .secondary_interrupt_enable(sie),
        .monitor_enable_ff(men), .digital_trip_ff(dtrip),
        .analog_trip_ff(atrip), .low_supply_irq_ff(irq));
    smc_core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .irq(irq),
        .irq_cnt_ff(irq_cnt));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // an idle cycle after each access avoids re-raising a strobe at once
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        tick(1);
        d = rdata;
        rd_en = 1'b0;
        chk(d, exp);
        tick(1);
    endtask : rd
    task automatic t_reset();
        rd(8'hDF, 8'hDE);
        rd(8'h5A, 8'h00);
        chk({3'h0, men, dtrip, atrip}, 8'h0F);
    endtask : t_reset
    task automatic t_fields();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'hDF, {3'h0, 2'(i), 2'(3 - i), 1'b1});
            chk({3'h0, men, dtrip, atrip},
                {4'h1, 2'(i), 2'(3 - i)});
            rd(8'hDF, {3'h6, 2'(i), 2'(3 - i), 1'b1});
        end
    endtask : t_fields
    task automatic t_glitch();
        wr(8'hDF, 8'h01);
        dig = 1'b0;
        tick(3);
        dig = 1'b1;
        tick(20);
        rd(8'hDF, 8'hC1);
        chk({7'h0, irq}, 8'h00);
    endtask : t_glitch
    task automatic t_low();
        ana = 1'b0;
        tick(20);
        rd(8'hDF, 8'hA1);
        chk({irq_cnt[6:0], irq}, 8'h03);
        wr(8'hDF, 8'h01);
        rd(8'hDF, 8'hA1);
        sie = 1'b0;
        tick(2);
        chk({7'h0, irq}, 8'h00);
        sie = 1'b1;
        // pending flag raises the request again once re-enabled
        tick(1);
        chk({7'h0, irq}, 8'h01);
    endtask : t_low
    task automatic t_restart();
        ana = 1'b1;
        tick(15);
        rd(8'hDF, 8'hE1);
        // drop lands before expiry; a resumed count would clear early
        ana = 1'b0;
        tick(15);
        ana = 1'b1;
        tick(15);
        rd(8'hDF, 8'hE1);
        tick(20);
        rd(8'hDF, 8'hC1);
        chk({irq_cnt[6:0], irq}, 8'h04);
    endtask : t_restart
    task automatic t_disable();
        wr(8'hDF, 8'h00);
        chk({7'h0, men}, 8'h00);
        dig = 1'b0;
        tick(20);
        rd(8'hDF, 8'h40);
        chk({7'h0, irq}, 8'h00);
        // software may set the flag even with the monitor off
        wr(8'hDF, 8'h20);
        rd(8'hDF, 8'h60);
    endtask : t_disable
    task automatic summarize();
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    initial
    begin
        tick(3);
        rstn = 1'b1;
        t_reset();
        t_fields();
        t_glitch();
        t_low();
        t_restart();
        t_disable();
        summarize();
    end
    // hang guard, far above the roughly 180 cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            summarize();
        end
    end
endmodule : smc_top_tb_top
